// file: hdl/pwm_and_square_wave_outputs.sv
/*
 * pulse-width generator and square-wave generator with per-pin routing
 * onto sixteen configurable i/o pins.
 * assumes software settings arrive as static ports on clk_sys; changes
 * to period values take effect at the next period boundary, except a square period of zero, which stops at once.
 */
// Operation
// - pwm frequency programmable, up to 500 kHz
// - pwm duty programmable from 0 to 100%
// - duty resolution equals steps per period
// - pwm routable onto any of sixteen pins
// - square wave shares frequency, per-pin duty
// - square wave 0 Hz to 4 MHz, default 50%
`timescale 1ns/10ps
`default_nettype none
module pwm_and_square_wave_outputs #(
	parameter int unsigned PWM_W  = pwm_sq_pkg::PWM_W,
	parameter int unsigned SQ_W   = pwm_sq_pkg::SQ_W,
	parameter int unsigned NPINS  = pwm_sq_pkg::NUM_PINS
) (
	input  wire logic                  clk_sys,
	input  wire logic                  resetn,
	input  wire logic                  pwm_enable,
	input  wire logic [PWM_W-1:0]      pwm_period_steps,
	input  wire logic [PWM_W-1:0]      pwm_duty_steps,
	input  wire logic                  sq_enable,
	input  wire logic [SQ_W-1:0]       sq_period_clks,
	input  wire logic [4*NPINS-1:0]    sq_duty_pin,
	input  wire logic [2*NPINS-1:0]    pin_function,
	input  wire logic [NPINS-1:0]      gpio_out,
	input  wire logic [NPINS-1:0]      gpio_oe,
	output var  logic [NPINS-1:0]      configurable_io_pin_o,
	output var  logic [NPINS-1:0]      configurable_io_pin_oe,
	output var  logic                  pwm_period_start,
	output var  logic                  square_wave_output
);
	// prescaler width, just enough for one step of system clocks
	localparam int unsigned STEP_CW = $clog2(pwm_sq_pkg::STEP_DIV);
	// duty step prescaler count
	logic [STEP_CW-1:0]     step_cnt_r, step_cnt_nxt;
	// one-cycle step tick
	logic                   step_tick_r, step_tick_nxt;
	// pwm position in the current period
	logic [PWM_W-1:0]       pwm_pos_r, pwm_pos_nxt;
	// period and duty latched at period start
	logic [PWM_W-1:0]       pwm_per_r, pwm_per_nxt;
	logic [PWM_W-1:0]       pwm_duty_r, pwm_duty_nxt;
	// internal pwm level
	logic                   pwm_lvl_r, pwm_lvl_nxt;
	// one-cycle marker of each new pwm period
	logic                   pwm_start_r, pwm_start_nxt;
	// square-wave count within its period, in system clocks
	logic [SQ_W-1:0]        sq_pos_r, sq_pos_nxt;
	// square period in use, reloaded at a period end or while idle
	logic [SQ_W-1:0]        sq_per_r, sq_per_nxt;
	// shared square-wave level and per-pin levels
	logic                   sq_lvl_r, sq_lvl_nxt;
	logic [NPINS-1:0]       sq_pin_r, sq_pin_nxt;
	// pin drive
	logic [NPINS-1:0]       pin_o_r, pin_o_nxt;
	logic [NPINS-1:0]       pin_oe_r, pin_oe_nxt;

	// high-time threshold for a pin: period scaled by duty sixteenths
	function automatic logic [SQ_W-1:0] sq_thresh(input logic [SQ_W-1:0] per,
			input logic [pwm_sq_pkg::SQ_DUTY_W-1:0] duty);
		logic [SQ_W+pwm_sq_pkg::SQ_DUTY_W-1:0] prod;
		prod = per * duty;
		return prod[SQ_W+pwm_sq_pkg::SQ_DUTY_W-1:pwm_sq_pkg::SQ_DUTY_W];
	endfunction : sq_thresh

	// running square period never shorter than the minimum; zero stays zero
	function automatic logic [SQ_W-1:0] sq_clamp(input logic [SQ_W-1:0] per);
		if (per != '0 && per < SQ_W'(pwm_sq_pkg::SQ_MIN_PER)) begin
			return SQ_W'(pwm_sq_pkg::SQ_MIN_PER);
		end
		return per;
	endfunction : sq_clamp

	// step prescaler and pwm counter next state
	always_comb begin
		step_cnt_nxt  = step_cnt_r + STEP_CW'(1);
		step_tick_nxt = 1'b0;
		if (step_cnt_r == STEP_CW'(pwm_sq_pkg::STEP_DIV - 1)) begin
			step_cnt_nxt  = '0;
			step_tick_nxt = 1'b1;
		end
		pwm_pos_nxt   = pwm_pos_r;
		pwm_per_nxt   = pwm_per_r;
		pwm_duty_nxt  = pwm_duty_r;
		pwm_lvl_nxt   = pwm_lvl_r;
		pwm_start_nxt = 1'b0;
		if (!pwm_enable) begin
			// idle low, restart cleanly when enabled
			pwm_pos_nxt = '0;
			pwm_lvl_nxt = 1'b0;
		end else if (step_tick_r) begin
			// period of N steps gives N duty steps of resolution
			if (pwm_pos_r + PWM_W'(1) >= pwm_per_r) begin
				pwm_pos_nxt   = '0;
				pwm_per_nxt   = (pwm_period_steps < PWM_W'(pwm_sq_pkg::PWM_MIN_PER))
				              ? PWM_W'(pwm_sq_pkg::PWM_MIN_PER) : pwm_period_steps;
				pwm_duty_nxt  = pwm_duty_steps;
				pwm_start_nxt = 1'b1;
				// duty of zero holds low, duty >= period holds high
				pwm_lvl_nxt   = (pwm_duty_steps != '0);
			end else begin
				pwm_pos_nxt = pwm_pos_r + PWM_W'(1);
				// compare against next position; no edge when duty >= period
				pwm_lvl_nxt = (pwm_pos_r + PWM_W'(1)) < pwm_duty_r;
			end
		end
	end

	// step and pwm registers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			step_cnt_r  <= '0;
			step_tick_r <= 1'b0;
			pwm_pos_r   <= '0;
			pwm_per_r   <= PWM_W'(pwm_sq_pkg::PWM_MIN_PER);
			pwm_duty_r  <= '0;
			pwm_lvl_r   <= 1'b0;
			pwm_start_r <= 1'b0;
		end else begin
			step_cnt_r  <= step_cnt_nxt;
			step_tick_r <= step_tick_nxt;
			pwm_pos_r   <= pwm_pos_nxt;
			pwm_per_r   <= pwm_per_nxt;
			pwm_duty_r  <= pwm_duty_nxt;
			pwm_lvl_r   <= pwm_lvl_nxt;
			pwm_start_r <= pwm_start_nxt;
		end
	end

	// square-wave counter next state; period zero means 0 Hz, held low
	always_comb begin
		sq_pos_nxt = sq_pos_r;
		sq_per_nxt = sq_per_r;
		sq_lvl_nxt = sq_lvl_r;
		sq_pin_nxt = sq_pin_r;
		// a zero request stops at once instead of finishing the running period
		if (!sq_enable || sq_per_r == '0 || sq_period_clks == '0) begin
			sq_pos_nxt = '0;
			sq_per_nxt = sq_clamp(sq_period_clks);
			sq_lvl_nxt = 1'b0;
			sq_pin_nxt = '0;
		end else begin
			// period of 2 clocks gives 5 MHz cap; minimum legal is 3 -> clamp below 4 MHz
			if (sq_pos_r + SQ_W'(1) >= sq_per_r) begin
				sq_pos_nxt = '0;
				sq_per_nxt = sq_clamp(sq_period_clks);
			end else begin
				sq_pos_nxt = sq_pos_r + SQ_W'(1);
			end
			// shared level, equal high and low halves by default
			sq_lvl_nxt = sq_pos_nxt < (sq_per_r >> 1);
			// one frequency, independent duty per pin
			for (int i = 0; i < NPINS; i++) begin
				sq_pin_nxt[i] = sq_pos_nxt < sq_thresh(sq_per_r,
					sq_duty_pin[pwm_sq_pkg::SQ_DUTY_W*i +: pwm_sq_pkg::SQ_DUTY_W]);
			end
		end
	end

	// square-wave registers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sq_pos_r <= '0;
			sq_per_r <= '0;
			sq_lvl_r <= 1'b0;
			sq_pin_r <= '0;
		end else begin
			sq_pos_r <= sq_pos_nxt;
			sq_per_r <= sq_per_nxt;
			sq_lvl_r <= sq_lvl_nxt;
			sq_pin_r <= sq_pin_nxt;
		end
	end

	// pin routing: each pin picks gpio, pwm or square wave, or is released on the unused code
	always_comb begin
		pin_o_nxt  = '0;
		pin_oe_nxt = '0;
		for (int i = 0; i < NPINS; i++) begin
			unique case (pin_function[pwm_sq_pkg::FN_W*i +: pwm_sq_pkg::FN_W])
				pwm_sq_pkg::FN_PWM: begin
					pin_o_nxt[i]  = pwm_lvl_r;
					pin_oe_nxt[i] = 1'b1;
				end
				pwm_sq_pkg::FN_SQ: begin
					pin_o_nxt[i]  = sq_pin_r[i];
					pin_oe_nxt[i] = 1'b1;
				end
				pwm_sq_pkg::FN_GPIO: begin
					pin_o_nxt[i]  = gpio_out[i];
					pin_oe_nxt[i] = gpio_oe[i];
				end
				default: begin
					// unused code: pin released
					pin_o_nxt[i]  = 1'b0;
					pin_oe_nxt[i] = 1'b0;
				end
			endcase
		end
	end

	// pin registers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pin_o_r  <= '0;
			pin_oe_r <= '0;
		end else begin
			pin_o_r  <= pin_o_nxt;
			pin_oe_r <= pin_oe_nxt;
		end
	end

	// every output comes straight from a register
	assign configurable_io_pin_o  = pin_o_r;
	assign configurable_io_pin_oe = pin_oe_r;
	assign pwm_period_start       = pwm_start_r;
	assign square_wave_output     = sq_lvl_r;
endmodule : pwm_and_square_wave_outputs
`default_nettype wire

// file: hdl/pwm_sq_pkg.sv
/*
 * constants for the pulse-width and square-wave output block.
 * assumes a 10 MHz system clock; duty steps tick at 1 MHz.
 */
`default_nettype none
package pwm_sq_pkg;
	// system clock rate in hz
	localparam int unsigned CLK_HZ      = 10_000_000;
	// duty step tick rate in hz
	localparam int unsigned STEP_HZ     = 1_000_000;
	// system clocks per duty step
	localparam int unsigned STEP_DIV    = CLK_HZ / STEP_HZ;
	// shortest pwm period in steps; one step alone would leave no duty resolution
	localparam int unsigned PWM_MIN_PER = 2;
	// shortest running square period in system clocks, keeps the rate below 4 MHz
	localparam int unsigned SQ_MIN_PER  = 3;
	// width of each pin's function select field
	localparam int unsigned FN_W        = 2;
	// number of output pins
	localparam int unsigned NUM_PINS    = 16;
	// width of the pwm period and duty counts in steps
	localparam int unsigned PWM_W       = 16;
	// width of the square-wave period count in system clocks
	localparam int unsigned SQ_W        = 24;
	// width of the per-pin duty setting, in sixteenths of a period
	localparam int unsigned SQ_DUTY_W   = 4;
	// per-pin duty reset value: half of sixteen, equal high and low
	localparam logic [3:0]  SQ_DUTY_RST = 4'h8;
	// pin function select codes
	localparam logic [1:0]  FN_GPIO     = 2'h0;
	localparam logic [1:0]  FN_PWM      = 2'h1;
	localparam logic [1:0]  FN_SQ       = 2'h2;
endpackage : pwm_sq_pkg
`default_nettype wire

// file: test/pwm_and_square_wave_outputs_bench.sv
/* self-checking bench for the pwm and square-wave block.
   assumes a 10 MHz clock and 1 us duty steps. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value %s exp %0d got %0d", nm, e, g); end end
module pwm_and_square_wave_outputs_bench;
	logic clk_sys = 0, resetn = 0, pwm_enable = 1, sq_enable = 1, ps, sqo;
	logic [15:0] pper = 16'h4, pdut = 16'h2, gout = 0, goe = 0, po, poe;
	logic [23:0] sper = 0;
	int num_errors = 0, compares = 0, cyc = 0;
	pwm_and_square_wave_outputs pwm_and_square_wave_outputs_i (.clk_sys(clk_sys),
		.resetn(resetn), .pwm_enable(pwm_enable), .pwm_period_steps(pper),
		.pwm_duty_steps(pdut), .sq_enable(sq_enable), .sq_period_clks(sper),
		.sq_duty_pin(64'h0000_0000_0000_4800), .pin_function(32'h0000_0DA4),
		.gpio_out(gout), .gpio_oe(goe), .configurable_io_pin_o(po),
		.configurable_io_pin_oe(poe), .pwm_period_start(ps), .square_wave_output(sqo));
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	// hang guard
	always @(posedge clk_sys) begin
		if (++cyc == 40000) begin
			num_errors++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : wrap_up
	task automatic wait_start();
		do @(negedge clk_sys); while (ps !== 1'b1);
	endtask : wait_start
	// one full pwm period on pin 1: length and high time
	task automatic t_pwm(input logic [15:0] p, input logic [15:0] d);
		int n = 0, h = 0;
		@(posedge clk_sys);
		pper <= p;
		pdut <= d;
		repeat (2) wait_start();
		do begin
			@(negedge clk_sys);
			n++;
			h += po[1];
		end while (ps !== 1'b1);
		`CHK("pwm period", p * 10, n)
		`CHK("pwm high", (d > p ? p : d) * 10, h)
	endtask : t_pwm
	// shared square frequency, per-pin duty 8 and 4 sixteenths
	task automatic t_sq(input logic [23:0] p);
		int w, a = 0, b = 0, s = 0;
		@(posedge clk_sys);
		sper <= p;
		repeat (100) @(negedge clk_sys);
		w = (p == 0) ? 100 : p * 10;
		repeat (w) begin
			@(negedge clk_sys);
			a += po[2];
			b += po[3];
			s += sqo;
		end
		`CHK("square high", w / 2 * (p != 0), s)
		`CHK("pin2 high", w / 2 * (p != 0), a)
		`CHK("pin3 high", w / 4 * (p != 0), b)
	endtask : t_sq
	// gpio pass-through on pin 0; pin 5 released
	task automatic t_gpio();
		for (int v = 0; v < 4; v++) begin
			@(posedge clk_sys);
			gout <= {16{v[0]}};
			goe  <= {16{v[1]}};
			@(posedge clk_sys);
			@(negedge clk_sys);
			`CHK("gpio level", v[0], po[0])
			`CHK("gpio enable", v[1], poe[0])
			`CHK("released enable", 0, poe[5])
		end
	endtask : t_gpio
	// both generators off: pwm pin, square level and square pin settle low
	task automatic t_off();
		@(posedge clk_sys);
		pwm_enable <= 1'h0;
		sq_enable  <= 1'h0;
		repeat (40) @(negedge clk_sys);
		`CHK("pwm idle", 1'h0, po[1])
		`CHK("pwm idle enable", 1'h1, poe[1])
		`CHK("square idle", 1'h0, sqo)
		`CHK("square pin idle", 1'h0, po[2])
	endtask : t_off
	initial begin
		repeat (20) @(posedge clk_sys);
		resetn <= 1;
		t_gpio();
		t_pwm(16'h2, 16'h1);
		t_pwm(16'hA, 16'h3);
		t_pwm(16'h4, 16'h0);
		t_pwm(16'h4, 16'hFFFF);
		t_pwm(16'h64, 16'h25);
		t_sq(24'h0);
		t_sq(24'h20);
		t_sq(24'h10);
		t_off();
		wrap_up();
	end
endmodule : pwm_and_square_wave_outputs_bench
`default_nettype wire

// file: test/pwm_sq_properties.sv
/* checker for the pwm and square-wave block, bound to its top module.
   assumes static settings and registered pin outputs. */
`timescale 1ns/10ps
`default_nettype none
module pwm_sq_checker #(
	parameter int unsigned PWM_W = 16,
	parameter int unsigned SQ_W  = 24,
	parameter int unsigned NPINS = 16
) (
	input wire logic               clk_sys,
	input wire logic               resetn,
	input wire logic               pwm_enable,
	input wire logic [PWM_W-1:0]   pwm_duty_steps,
	input wire logic               sq_enable,
	input wire logic [SQ_W-1:0]    sq_period_clks,
	input wire logic [2*NPINS-1:0] pin_function,
	input wire logic [NPINS-1:0]   gpio_out,
	input wire logic [NPINS-1:0]   configurable_io_pin_o,
	input wire logic [NPINS-1:0]   configurable_io_pin_oe,
	input wire logic               pwm_period_start,
	input wire logic               square_wave_output
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// eight high clocks then low: half of a sixteen-clock square period
	sequence sq_high8;
		square_wave_output[*8] ##1 !square_wave_output;
	endsequence
	// pwm duty of 0 or full, seen on pin 1 routed to pwm
	sequence pwm_edge(logic [PWM_W-1:0] dv);
		pwm_enable && pwm_period_start && $stable(pwm_duty_steps) && pwm_duty_steps == dv
			&& pin_function[3:2] == pwm_sq_pkg::FN_PWM;
	endsequence
	start_pulse_a: assert property (
		pwm_period_start |=> (!pwm_period_start)[*8]) else $error("period start pulse too long");
	pwm_quiet_a: assert property (
		(!pwm_enable)[*3] |-> !pwm_period_start) else $error("pwm runs while disabled");
	gpio_pass_a: assert property (
		$past(resetn) && pin_function[1:0] == pwm_sq_pkg::FN_GPIO
		|=> configurable_io_pin_o[0] == $past(gpio_out[0])) else $error("gpio pin wrong");
	pwm_pins_a: assert property (
		$past(resetn) && pin_function[3:2] == pwm_sq_pkg::FN_PWM && pin_function[9:8] == 2'h1
		|=> configurable_io_pin_o[1] == configurable_io_pin_o[4] && configurable_io_pin_oe[1])
		else $error("pwm pins differ");
	duty_zero_a: assert property (
		pwm_edge(16'h0) |=> (!configurable_io_pin_o[1])[*8]) else $error("pulse at zero duty");
	duty_full_a: assert property (
		pwm_edge(16'hFFFF) |=> configurable_io_pin_o[1][*8]) else $error("gap at full duty");
	sq_idle_a: assert property (
		(!sq_enable || sq_period_clks == 0)[*3] |-> !square_wave_output) else $error("square not idle");
	sq_half_a: assert property (
		$rose(square_wave_output) && $stable(sq_period_clks) && sq_period_clks == 24'h10
		|-> sq_high8) else $error("square not half high");
endmodule : pwm_sq_checker
bind pwm_and_square_wave_outputs pwm_sq_checker #(.PWM_W(PWM_W), .SQ_W(SQ_W), .NPINS(NPINS))
	pwm_sq_checker_i (.clk_sys(clk_sys), .resetn(resetn), .pwm_enable(pwm_enable),
	.pwm_duty_steps(pwm_duty_steps), .sq_enable(sq_enable), .sq_period_clks(sq_period_clks),
	.pin_function(pin_function), .gpio_out(gpio_out), .configurable_io_pin_o(configurable_io_pin_o),
	.configurable_io_pin_oe(configurable_io_pin_oe), .pwm_period_start(pwm_period_start),
	.square_wave_output(square_wave_output));
`default_nettype wire
